/* hw/shbhp_regs.svh */
// Bit positions and reset values of the shared bus host port
`ifndef SHBHP_REGS_SVH
`define SHBHP_REGS_SVH
`define SHBHP_BUS_W 16
`define SHBHP_CMD_BIT 16
`define SHBHP_BE_MSB 15
`define SHBHP_BE_LSB 12
`define SHBHP_A16_MSB 10
`define SHBHP_A16_LSB 2
`define SHBHP_BYTE_MSB 7
`define SHBHP_A8HI_MSB 2
`define SHBHP_ADDR_W 11
`define SHBHP_PIN_RST 4'h7
`define SHBHP_ADDR_RST 11'h000
`define SHBHP_BE_RST 4'h0
`define SHBHP_DATA_RST 16'h0000
`define SHBHP_BE8_ONE 4'h1
`endif

/* hw/shbhp_pkg.sv */
// Types of the shared bus host port
package shbhp_pkg;
   typedef enum logic [1:0] {
      SHBHP_IDLE = 2'b00,
      SHBHP_WRITE = 2'b01,
      SHBHP_READ = 2'b11
   } shbhp_state_t;
endpackage : shbhp_pkg

/* hw/shbhp_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module shbhp_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] stage_o,
   output logic [WIDTH-1:0] filt_o
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   logic [WIDTH-1:0] filt;
   logic [WIDTH-1:0] next_filt;

   initial begin
      if (WIDTH < 1) $error("shbhp_sync: WIDTH must be at least 1");
   end

   // A bit moves only once the second and third stages agree
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
         filt <= RST_VAL;
      end else begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
         filt <= next_filt;
      end
   end

   assign stage_o = s3;
   assign filt_o = filt;
endmodule : shbhp_sync

/* hw/shbhp_top.sv */
// Shared bus host port: device end of the asynchronous parallel host bus
//
// Notes on behaviour
// - With command-type low a cycle carries data, on all sixteen lines in 16-bit mode or the low eight in 8-bit mode.
// - In 16-bit mode an address cycle takes address bits 10..2 from lines 10..2 and ignores lines 1 and 0.
// - In 16-bit mode an address cycle takes four byte-lane enables from lines 15..12 and ignores line 11.
// - In 8-bit mode the address comes in two writes, bits 7..0 first, then bits 10..8 on lines 2..0 with 7..3 ignored.
// - The interrupt output is pulled low while any interrupt status bit is set and released otherwise.
// - Reads are low pulses of the read strobe, treated as asynchronous to the device clock.
// - Address and data writes are low pulses of the write strobe, accepted asynchronously.
// - Strobes count only while chip select is held low.
// - Each byte-lane enable is active high and selects its byte of the double word.
`timescale 1ns/1ps
`include "shbhp_regs.svh"
module shbhp_top #(
   parameter int IRQ_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic bus_width_16_i,
   input wire logic cmd_i,
   input wire logic chip_select_n_i,
   input wire logic read_strobe_n_i,
   input wire logic write_strobe_n_i,
   input wire logic [`SHBHP_BUS_W-1:0] shared_bus_line_i,
   output logic [`SHBHP_BUS_W-1:0] shared_bus_line_o,
   output logic [`SHBHP_BUS_W-1:0] shared_bus_line_oe_o,
   output logic irq_out_n_o,
   output logic irq_out_n_oe_o,
   input wire logic [IRQ_W-1:0] irq_status_i,
   output logic [`SHBHP_ADDR_W-1:0] reg_addr_o,
   output logic [3:0] byte_lane_enable_o,
   output logic wr_req_o,
   output logic [`SHBHP_BUS_W-1:0] wr_data_o,
   output logic rd_req_o,
   input wire logic [`SHBHP_BUS_W-1:0] rd_data_i
);
   initial begin
      if (IRQ_W < 1) $error("shbhp_top: IRQ_W must be at least 1");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation
   logic [3:0] pin_stage;
   logic [3:0] pin_filt;
   logic mode16;
   logic cs_act;
   logic wr_act;
   logic rd_act;
   logic wr_low3;

   shbhp_sync #(.WIDTH(4), .RST_VAL(`SHBHP_PIN_RST)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i({bus_width_16_i, chip_select_n_i, read_strobe_n_i, write_strobe_n_i}),
      .stage_o(pin_stage),
      .filt_o(pin_filt)
   );

   assign mode16 = pin_filt[3];
   assign cs_act = !pin_filt[2];
   assign rd_act = cs_act && !pin_filt[1];
   assign wr_act = cs_act && !pin_filt[0];
   assign wr_low3 = !pin_stage[2] && !pin_stage[0];

   ////////////////////////////////////////////////////////////////////////////
   // Bus sampling, delayed to line up with the third strobe stage
   logic [`SHBHP_CMD_BIT:0] bus_d1;
   logic [`SHBHP_CMD_BIT:0] bus_d2;
   logic [`SHBHP_CMD_BIT:0] bus_d3;
   logic [`SHBHP_CMD_BIT:0] bus_hold;
   logic [`SHBHP_CMD_BIT:0] next_bus_hold;

   // Keep the last sample taken while the strobe was still low, so a host
   // changing the lines right after release cannot corrupt the capture
   always_comb begin
      next_bus_hold = wr_low3 ? bus_d3 : bus_hold;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_d1 <= '0;
         bus_d2 <= '0;
         bus_d3 <= '0;
         bus_hold <= '0;
      end else begin
         bus_d1 <= {cmd_i, shared_bus_line_i};
         bus_d2 <= bus_d1;
         bus_d3 <= bus_d2;
         bus_hold <= next_bus_hold;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Access control
   shbhp_pkg::shbhp_state_t state;
   shbhp_pkg::shbhp_state_t next_state;
   logic addr_phase;
   logic next_addr_phase;
   logic rd_ok;
   logic next_rd_ok;
   logic rd_load;
   logic next_rd_load;
   logic [`SHBHP_ADDR_W-1:0] next_reg_addr;
   logic [3:0] next_be;
   logic next_wr_req;
   logic [`SHBHP_BUS_W-1:0] next_wr_data;
   logic next_rd_req;
   logic [`SHBHP_BUS_W-1:0] next_bus_out;
   logic [`SHBHP_BUS_W-1:0] next_bus_oe;
   logic end_write;
   logic hold_cmd;

   assign end_write = (state == shbhp_pkg::SHBHP_WRITE) && !wr_act;
   assign hold_cmd = bus_hold[`SHBHP_CMD_BIT];

   always_comb begin
      next_state = state;
      next_addr_phase = addr_phase;
      next_rd_ok = rd_ok;
      next_rd_load = 1'b0;
      next_reg_addr = reg_addr_o;
      next_be = byte_lane_enable_o;
      next_wr_req = 1'b0;
      next_wr_data = wr_data_o;
      next_rd_req = 1'b0;
      next_bus_out = shared_bus_line_o;
      next_bus_oe = '0;
      case (state)
         shbhp_pkg::SHBHP_IDLE: begin
            if (wr_act) begin
               next_state = shbhp_pkg::SHBHP_WRITE;
            end else if (rd_act) begin
               next_state = shbhp_pkg::SHBHP_READ;
               // A read with command-type high carries no data
               next_rd_ok = !bus_d3[`SHBHP_CMD_BIT];
               next_rd_req = !bus_d3[`SHBHP_CMD_BIT];
               next_rd_load = !bus_d3[`SHBHP_CMD_BIT];
            end
         end
         shbhp_pkg::SHBHP_WRITE: begin
            if (!wr_act) begin
               next_state = shbhp_pkg::SHBHP_IDLE;
               if (!hold_cmd) begin
                  next_wr_req = 1'b1;
                  next_wr_data = mode16 ? bus_hold[`SHBHP_BUS_W-1:0] :
                     {8'h00, bus_hold[`SHBHP_BYTE_MSB:0]};
               end else if (mode16) begin
                  // Lines 11, 1 and 0 are dropped on purpose
                  next_reg_addr = {bus_hold[`SHBHP_A16_MSB:`SHBHP_A16_LSB], 2'b00};
                  next_be = bus_hold[`SHBHP_BE_MSB:`SHBHP_BE_LSB];
                  next_addr_phase = 1'b0;
               end else if (!addr_phase) begin
                  next_reg_addr = {reg_addr_o[`SHBHP_ADDR_W-1:8], bus_hold[`SHBHP_BYTE_MSB:0]};
                  next_be = 4'(`SHBHP_BE8_ONE << bus_hold[1:0]);
                  next_addr_phase = 1'b1;
               end else begin
                  next_reg_addr = {bus_hold[`SHBHP_A8HI_MSB:0], reg_addr_o[7:0]};
                  next_addr_phase = 1'b0;
               end
            end
         end
         shbhp_pkg::SHBHP_READ: begin
            if (rd_load) begin
               next_bus_out = rd_data_i;
            end
            if (!rd_act) begin
               next_state = shbhp_pkg::SHBHP_IDLE;
               next_rd_ok = 1'b0;
            end else if (rd_ok) begin
               // Upper lines stay undriven in 8-bit mode since the board ties them low
               next_bus_oe = mode16 ? 16'hFFFF : 16'h00FF;
            end
         end
         default: begin
            next_state = shbhp_pkg::SHBHP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= shbhp_pkg::SHBHP_IDLE;
         addr_phase <= 1'b0;
         rd_ok <= 1'b0;
         rd_load <= 1'b0;
         reg_addr_o <= `SHBHP_ADDR_RST;
         byte_lane_enable_o <= `SHBHP_BE_RST;
         wr_req_o <= 1'b0;
         wr_data_o <= `SHBHP_DATA_RST;
         rd_req_o <= 1'b0;
         shared_bus_line_o <= `SHBHP_DATA_RST;
         shared_bus_line_oe_o <= '0;
      end else begin
         state <= next_state;
         addr_phase <= next_addr_phase;
         rd_ok <= next_rd_ok;
         rd_load <= next_rd_load;
         reg_addr_o <= next_reg_addr;
         byte_lane_enable_o <= next_be;
         wr_req_o <= next_wr_req;
         wr_data_o <= next_wr_data;
         rd_req_o <= next_rd_req;
         shared_bus_line_o <= next_bus_out;
         shared_bus_line_oe_o <= next_bus_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt pin, open drain: only ever drives low
   logic irq_drive;
   logic next_irq_drive;

   always_comb begin
      next_irq_drive = |irq_status_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_drive <= 1'b0;
      end else begin
         irq_drive <= next_irq_drive;
      end
   end

   assign irq_out_n_o = 1'b0;
   assign irq_out_n_oe_o = irq_drive;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_IRQ_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      (|irq_status_i) |=> irq_out_n_oe_o && !irq_out_n_o)
      else $error("interrupt pin not pulled low while status set");

   AST_IRQ_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      !(|irq_status_i) |=> !irq_out_n_oe_o)
      else $error("interrupt pin driven with no status set");

   AST_WR_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
      (end_write && !hold_cmd && !mode16) |=> wr_req_o && wr_data_o == {8'h00, $past(bus_hold[7:0])})
      else $error("8-bit data write wrong");

   AST_ADDR16: assert property (@(posedge clk_i) disable iff (rst_i)
      (end_write && hold_cmd && mode16) |=>
         reg_addr_o == {$past(bus_hold[10:2]), 2'b00} && !wr_req_o)
      else $error("16-bit address capture wrong");

   AST_BE16: assert property (@(posedge clk_i) disable iff (rst_i)
      (end_write && hold_cmd && mode16) |=> byte_lane_enable_o == $past(bus_hold[15:12]))
      else $error("byte-lane enables not taken from lines 15..12");

   AST_ADDR8_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
      (end_write && hold_cmd && !mode16 && addr_phase) |=>
         reg_addr_o[10:8] == $past(bus_hold[2:0]) && !addr_phase && $stable(reg_addr_o[7:0]))
      else $error("8-bit second address write wrong");

   AST_RD_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_req_o |-> state == shbhp_pkg::SHBHP_READ ##1 !rd_req_o)
      else $error("read request not a single pulse inside a read");

   AST_CS_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == shbhp_pkg::SHBHP_IDLE && !cs_act) |=> !wr_req_o && !rd_req_o && state == shbhp_pkg::SHBHP_IDLE)
      else $error("access started without chip select");

   AST_OE_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      (|shared_bus_line_oe_o) |-> $past(rd_act) && rd_ok && (mode16 || shared_bus_line_oe_o[15:8] == 8'h00))
      else $error("bus driven outside a data read");

   AST_WR_AT_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(wr_req_o) |-> $past(state) == shbhp_pkg::SHBHP_WRITE && !$past(wr_act))
      else $error("write request not at strobe release");
endmodule : shbhp_top

/* bench/shbhp_host.sv */
// Host processor model that drives the shared asynchronous bus
`timescale 1ns/1ps
module shbhp_host (
   input wire logic clk_i,
   input wire logic wide_i,
   input wire logic [15:0] bus_i,
   output logic chip_select_n_o,
   output logic read_strobe_n_o,
   output logic write_strobe_n_o,
   output logic cmd_o,
   output logic [15:0] bus_o
);
   initial begin
      chip_select_n_o = 1'b1;
      read_strobe_n_o = 1'b1;
      write_strobe_n_o = 1'b1;
      cmd_o = 1'b0;
      bus_o = 16'h0000;
   end

   // Released lines get the inverse (upper eight zero in 8-bit mode) so a stale value cannot pass
   task automatic idle(input logic [15:0] val);
      bus_o = wide_i ? ~val : {8'h00, ~val[7:0]};
   endtask : idle

   task automatic wr(input logic cmd, input logic [15:0] val, input logic sel);
      @(negedge clk_i);
      cmd_o = cmd;
      bus_o = val;
      chip_select_n_o = ~sel;
      write_strobe_n_o = 1'b0;
      repeat (6) @(negedge clk_i);
      write_strobe_n_o = 1'b1;
      @(negedge clk_i);
      chip_select_n_o = 1'b1;
      idle(val);
      repeat (6) @(negedge clk_i);
   endtask : wr

   task automatic rd(input logic cmd, output logic [15:0] d);
      @(negedge clk_i);
      cmd_o = cmd;
      chip_select_n_o = 1'b0;
      read_strobe_n_o = 1'b0;
      // Sample away from the clock edge so the driven data has settled
      repeat (8) @(negedge clk_i);
      d = bus_i;
      read_strobe_n_o = 1'b1;
      @(negedge clk_i);
      chip_select_n_o = 1'b1;
      repeat (6) @(negedge clk_i);
   endtask : rd
endmodule : shbhp_host

/* bench/testbench.sv */
// Self-checking testbench of the shared bus host port
`timescale 1ns/1ps
module testbench;
   logic clk_i, rst_i, bw, cs_n, rd_n, wr_n, cmd, irq_n, irq_oe, wr_req, rd_req;
   logic [15:0] host_bus, dev_o, dev_oe, wr_data, rdd, wr_last, wr_cnt, rd_cnt;
   logic [10:0] addr;
   logic [3:0] be;
   logic [7:0] irq;
   wire logic [15:0] line = (dev_oe & dev_o) | (~dev_oe & host_bus);
   int failures = 0;
   int check_count = 0;

   shbhp_top uut (.clk_i(clk_i), .rst_i(rst_i), .bus_width_16_i(bw), .cmd_i(cmd),
      .chip_select_n_i(cs_n), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n),
      .shared_bus_line_i(line), .shared_bus_line_o(dev_o), .shared_bus_line_oe_o(dev_oe),
      .irq_out_n_o(irq_n), .irq_out_n_oe_o(irq_oe), .irq_status_i(irq), .reg_addr_o(addr),
      .byte_lane_enable_o(be), .wr_req_o(wr_req), .wr_data_o(wr_data), .rd_req_o(rd_req),
      .rd_data_i(rdd));
   shbhp_host host (.clk_i(clk_i), .wide_i(bw), .bus_i(line), .chip_select_n_o(cs_n),
      .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .cmd_o(cmd), .bus_o(host_bus));

   ////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wr_cnt <= 16'h0000;
         rd_cnt <= 16'h0000;
      end else begin
         if (wr_req === 1'b1) begin
            wr_cnt <= wr_cnt + 16'h0001;
            wr_last <= wr_data;
         end
         if (rd_req === 1'b1) rd_cnt <= rd_cnt + 16'h0001;
      end
   end

   // Data as it travels on the bus in the given width
   function automatic logic [15:0] exp_data(input logic wide, input logic [15:0] val);
      exp_data = wide ? val : {8'h00, val[7:0]};
   endfunction : exp_data

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic finish_test();
      if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] a, v, d, n;
      rst_i = 1'b1;
      bw = 1'b1;
      irq = 8'h00;
      rdd = 16'h0000;
      a = 16'($urandom(32'h7883B679));
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (6) @(negedge clk_i);
      for (int i = 0; i < 6; i++) begin
         // All-ones corner sets the ignored lines as well
         a = (i == 0) ? 16'hFFFF : 16'($urandom);
         host.wr(1'b1, a, 1'b1);
         chk("addr16", {7'h00, a[10:2]}, {7'h00, addr[10:2]});
         chk("be16", {12'h000, a[15:12]}, {12'h000, be});
         v = 16'($urandom);
         n = wr_cnt;
         host.wr(1'b0, v, 1'b1);
         chk("wr_count", n + 16'h0001, wr_cnt);
         chk("wr_data16", exp_data(1'b1, v), wr_last);
         host.wr(1'b0, ~v, 1'b0);
         chk("wr_no_select", n + 16'h0001, wr_cnt);
         rdd = 16'($urandom);
         n = rd_cnt;
         host.rd(1'b0, d);
         chk("rd_data16", exp_data(1'b1, rdd), d);
         chk("rd_count", n + 16'h0001, rd_cnt);
         host.rd(1'b1, d);
         chk("rd_cmd_high", n + 16'h0001, rd_cnt);
         chk("rd_cmd_high_bus", exp_data(1'b1, v), d);
      end
      bw = 1'b0;
      repeat (8) @(negedge clk_i);
      for (int i = 0; i < 6; i++) begin
         a = 16'($urandom);
         host.wr(1'b1, {8'h00, a[7:0]}, 1'b1);
         host.wr(1'b1, {8'h00, a[15:11], a[10:8]}, 1'b1);
         chk("addr8", {5'h00, a[10:0]}, {5'h00, addr});
         chk("be8", 16'h0001 << a[1:0], {12'h000, be});
         v = 16'($urandom);
         host.wr(1'b0, {8'h00, v[7:0]}, 1'b1);
         chk("wr_data8", exp_data(1'b0, v), wr_last);
         rdd = 16'($urandom);
         host.rd(1'b0, d);
         chk("rd_data8", exp_data(1'b0, rdd), d);
      end
      for (int i = 0; i < 9; i++) begin
         @(negedge clk_i);
         irq = (i % 3 == 0) ? 8'h00 : 8'($urandom);
         @(negedge clk_i);
         chk("irq_level", 16'h0000, {15'h0000, irq_n});
         chk("irq_drive", {15'h0000, |irq}, {15'h0000, irq_oe});
      end
      finish_test();
   end
endmodule : testbench
